/* File: multi_queue_status_flag_logic.sv */
// Status flag generation for a four-queue store: full/input-ready, composite, almost flags.
// Assumes storage outside follows store_en_o; one clock carries both the write and read sides.
//
// Function
// (RULE1) Fall-through select pin latched at master reset picks full or input-ready flags.
// (RULE2) Standard: full flag low on edge storing last word; writes blocked until high.
// (RULE3) Fall-through: input-ready low while space remains, high after the last word.
// (RULE4) Fall-through capacity counts the output register word, one more write.
// (RULE5) Broadcast: any full queue blocks writes to all four queues.
// (RULE6) Otherwise a full queue blocks only its own writes; flags independent. Here its stalled head write holds later buffered writes to any queue.
// (RULE7) Full/input-ready flags update on write edges through two register stages.
// (RULE8) Standard: full flag releases two write cycles after a read frees space.
// (RULE9) Fall-through: input-ready drops two write cycles after a read frees space.
// (RULE10) Composite flag mirrors selected write queue, only in demux and broadcast.
// (RULE11) Composite flag shows new queue one cycle after the selecting edge.
// (RULE12) Almost-empty low at n words or fewer, n-1 in fall-through.
// (RULE13) Each queue has its own empty offset and almost-empty flag.
// (RULE14) Flag timing pin latched at reset: high synchronous, low asynchronous.
// (RULE15) Almost-empty sync on read edges; async asserts on read, releases on write.
// (RULE16) Almost-full low after D-m writes, D+1-m in fall-through.
// (RULE17) Each queue has its own full offset and almost-full flag.
// (RULE18) Almost-full sync on write edges; async asserts on write, releases on read.
// (RULE19) Async almost-empty releases on a write once occupancy exceeds threshold.
// (RULE20) Offsets load serially, one bit per shift clock rise while enable low.
// (RULE21) Queue depth is a build constant; counters hold depth plus one.
// (RULE22) Occupancy crossing between write and read views passes two stages.
`timescale 1ns/1ps

module multi_queue_status_flag_logic
  import mqf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic fallthrough_select_serial_in_i,
  input wire logic flag_timing_select_i,
  input wire logic [1:0] port_mode_i,
  input wire logic serial_clk_i,
  input wire logic serial_load_enable_n_i,
  input wire logic wr_valid_i,
  input wire logic [`MQF_SEL_W-1:0] wr_sel_i,
  input wire logic [`MQF_DATA_W-1:0] wr_data_i,
  output logic wr_ready_o,
  input wire logic [`MQF_NUM_Q-1:0] rd_en_i,
  output logic [`MQF_NUM_Q-1:0] store_en_o,
  output logic [`MQF_DATA_W-1:0] store_data_o,
  output logic [`MQF_NUM_Q-1:0] queue_full_n_o,
  output logic selected_queue_full_n_o,
  output logic [`MQF_NUM_Q-1:0] almost_empty_n_o,
  output logic [`MQF_NUM_Q-1:0] almost_full_n_o,
  output logic fallthrough_timing_o
);

  localparam int NQ = `MQF_NUM_Q;
  localparam int CW = `MQF_CNT_W;
  localparam int BW = `MQF_SEL_W + `MQF_DATA_W;

  // Almost-empty threshold: count <= n, or count <= n-1 in fall-through
  function automatic logic ae_cond(input count_t cnt, input count_t n, input logic ft);
    ae_cond = ({1'b0, cnt} + {{CW{1'b0}}, ft}) <= {1'b0, n};
  endfunction

  // Almost-full threshold: count >= D-m, or count >= D+1-m in fall-through
  function automatic logic af_cond(input count_t cnt, input count_t m, input logic ft);
    af_cond = ({1'b0, cnt} + {1'b0, m}) >= ({1'b0, `MQF_QDEPTH} + {{CW{1'b0}}, ft});
  endfunction

  // One-hot queue decode
  function automatic logic [NQ-1:0] qdec(input qsel_t s);
    qdec = NQ'(1) << s;
  endfunction

  // Options caught at master reset
  logic fallthrough_timing_q, pfm_q;
  logic [`MQF_OFS_CHAIN_W-1:0] ofs_q;
  logic sclk_q;

  // Per-queue occupancy: write view, read view, true count
  count_t wcnt_q [NQ];
  count_t rcnt_q [NQ];
  count_t tcnt_q [NQ];
  count_t wcnt_d [NQ];
  count_t rcnt_d [NQ];
  count_t tcnt_d [NQ];
  logic [NQ-1:0] rd_s1_q, rd_s2_q, wr_s1_q, wr_s2_q;
  logic [NQ-1:0] flag_q, flag_d, ae_q, ae_d, af_q, af_d;
  logic [NQ-1:0] full_now, rd_evt, wr_evt;
  qsel_t sel_q;
  logic comp_q;
  logic [NQ-1:0] store_en_q;
  logic [`MQF_DATA_W-1:0] store_data_q;
  logic buf_vld, take;
  logic [BW-1:0] buf_dat;

  // Request buffer; a blocked head stalls it, and once it fills the producer sees ready low
  mqf_buffer #(.WIDTH(BW), .DEPTH(`MQF_BUF_DEPTH)) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(wr_valid_i),
    .in_data_i({wr_sel_i, wr_data_i}),
    .in_ready_o(wr_ready_o),
    .out_valid_o(buf_vld),
    .out_data_o(buf_dat),
    .out_ready_i(take)
  );

  // Write targeting and blocking
  wire bcast = (port_mode_i == MODE_BCAST);
  wire comp_on = (port_mode_i == MODE_DEMUX) || bcast;
  wire qsel_t head_sel = buf_dat[BW-1 -: `MQF_SEL_W];
  wire [NQ-1:0] wants = bcast ? {NQ{1'b1}} : qdec(head_sel);
  wire count_t cap = `MQF_QDEPTH + count_t'(fallthrough_timing_q); // see (RULE4) (RULE21)
  wire blocked = bcast ? (|full_now) : (|(wants & full_now)); // see (RULE5) (RULE6)
  assign take = buf_vld & ~blocked; // see (RULE2) (RULE3)
  assign wr_evt = take ? wants : '0;
  assign rd_evt = rd_en_i & ~{(rcnt_q[3] == '0), (rcnt_q[2] == '0),
                              (rcnt_q[1] == '0), (rcnt_q[0] == '0)};

  // Serial offset shifting on rising edges of the shift clock
  wire sclk_rise = serial_clk_i & ~sclk_q;

  // Per-queue count arithmetic and flag decisions
  genvar g;
  generate
    for (g = 0; g < NQ; g++) begin : g_q
      wire count_t eofs = ofs_q[`MQF_EMPTY_OFS_POS + g*CW +: CW]; // see (RULE13)
      wire count_t fofs = ofs_q[`MQF_FULL_OFS_POS + g*CW +: CW]; // see (RULE17)
      assign full_now[g] = (wcnt_q[g] == cap);
      // Write view frees space only after the read has crossed two stages
      assign wcnt_d[g] = wcnt_q[g] + count_t'(wr_evt[g]) - count_t'(rd_s2_q[g]); // see (RULE22)
      assign rcnt_d[g] = rcnt_q[g] + count_t'(wr_s2_q[g]) - count_t'(rd_evt[g]);
      assign tcnt_d[g] = tcnt_q[g] + count_t'(wr_evt[g]) - count_t'(rd_evt[g]);
      // Full flag high when not full; input-ready low when not full
      assign flag_d[g] = (wcnt_d[g] == cap) ? fallthrough_timing_q : ~fallthrough_timing_q; // see (RULE2) (RULE3) (RULE8) (RULE9)
      // Almost-empty: sync from read view, async set by reads, cleared by writes
      assign ae_d[g] = pfm_q ? ~ae_cond(rcnt_d[g], eofs, fallthrough_timing_q) : // see (RULE12) (RULE15)
                       (rd_evt[g] && ae_cond(tcnt_d[g], eofs, fallthrough_timing_q)) ? 1'b0 :
                       (wr_evt[g] && !ae_cond(tcnt_d[g], eofs, fallthrough_timing_q)) ? 1'b1 : // see (RULE19)
                       ae_q[g];
      // Almost-full: sync from write view, async set by writes, cleared by reads
      assign af_d[g] = pfm_q ? ~af_cond(wcnt_d[g], fofs, fallthrough_timing_q) : // see (RULE16) (RULE18)
                       (wr_evt[g] && af_cond(tcnt_d[g], fofs, fallthrough_timing_q)) ? 1'b0 :
                       (rd_evt[g] && !af_cond(tcnt_d[g], fofs, fallthrough_timing_q)) ? 1'b1 :
                       af_q[g];

      // Occupancy counters
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          wcnt_q[g] <= '0;
          rcnt_q[g] <= '0;
          tcnt_q[g] <= '0;
        end else if (ce_i) begin
          wcnt_q[g] <= wcnt_d[g];
          rcnt_q[g] <= rcnt_d[g];
          tcnt_q[g] <= tcnt_d[g];
        end
      end
    end
  endgenerate

  // Mode pins caught and offsets defaulted at master reset, serial load after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fallthrough_timing_q <= fallthrough_select_serial_in_i; // see (RULE1)
      pfm_q <= flag_timing_select_i; // see (RULE14)
      ofs_q <= {{NQ{`MQF_FULL_OFS_RST}}, {NQ{`MQF_EMPTY_OFS_RST}}};
      sclk_q <= 1'b0;
    end else if (ce_i) begin
      sclk_q <= serial_clk_i;
      if (sclk_rise && !serial_load_enable_n_i) begin
        ofs_q <= {ofs_q[`MQF_OFS_CHAIN_W-2:0], fallthrough_select_serial_in_i}; // see (RULE20)
      end
    end
  end

  // Crossing stages between the write and read views
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_s1_q <= '0;
      rd_s2_q <= '0;
      wr_s1_q <= '0;
      wr_s2_q <= '0;
    end else if (ce_i) begin
      rd_s1_q <= rd_evt; // see (RULE22)
      rd_s2_q <= rd_s1_q;
      wr_s1_q <= wr_evt;
      wr_s2_q <= wr_s1_q;
    end
  end

  // Flag registers: loaded from the next count, on the same edge as the count registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= {NQ{~fallthrough_select_serial_in_i}};
      ae_q <= '0;
      af_q <= '1;
    end else if (ce_i) begin
      flag_q <= flag_d; // see (RULE7)
      ae_q <= ae_d;
      af_q <= af_d;
    end
  end

  // Composite flag follows the queue selected on the write port in demux and broadcast modes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= '0;
      comp_q <= ~fallthrough_select_serial_in_i;
    end else if (ce_i) begin
      sel_q <= wr_sel_i;
      comp_q <= comp_on ? flag_d[sel_q] : ~fallthrough_timing_q; // see (RULE10) (RULE11)
    end
  end

  // Store strobes toward the queue memories
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      store_en_q <= '0;
      store_data_q <= '0;
    end else if (ce_i) begin
      store_en_q <= wr_evt;
      store_data_q <= buf_dat[`MQF_DATA_W-1:0];
    end
  end

  assign store_en_o = store_en_q;
  assign store_data_o = store_data_q;
  assign queue_full_n_o = flag_q;
  assign selected_queue_full_n_o = comp_q;
  assign almost_empty_n_o = ae_q;
  assign almost_full_n_o = af_q;
  assign fallthrough_timing_o = fallthrough_timing_q;

  // Per-queue checks use queue 0, which stands for all four; the write blocking and composite checks cover any queue
  wire count_t e0 = ofs_q[`MQF_EMPTY_OFS_POS +: CW];
  wire count_t f0 = ofs_q[`MQF_FULL_OFS_POS +: CW];

  property p_mode_held;
    @(posedge clk_i) disable iff (rst_i) $stable(fallthrough_timing_o) && $stable(pfm_q);
  endproperty
  a_mode_held: assert property (p_mode_held) // see (RULE1) (RULE14)
    else $error("timing options changed outside reset");

  property p_full_blocks;
    @(posedge clk_i) disable iff (rst_i) (buf_vld && full_now[head_sel]) |-> !take;
  endproperty
  a_full_blocks: assert property (p_full_blocks) // see (RULE2) (RULE3)
    else $error("write taken into a full queue");

  property p_bcast_block;
    @(posedge clk_i) disable iff (rst_i) (bcast && |full_now) |-> !take;
  endproperty
  a_bcast_block: assert property (p_bcast_block) // see (RULE5)
    else $error("broadcast write taken while a queue is full");

  property p_indep;
    @(posedge clk_i) disable iff (rst_i)
      (!bcast && buf_vld && !full_now[head_sel]) |-> take && (wr_evt == qdec(head_sel));
  endproperty
  a_indep: assert property (p_indep) // see (RULE6)
    else $error("write to a free queue was held back");

  property p_std_release;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (!fallthrough_timing_q && rd_evt[0] && full_now[0])
      |=> !queue_full_n_o[0] ##1 !queue_full_n_o[0] ##1 queue_full_n_o[0];
  endproperty
  a_std_release: assert property (p_std_release) // see (RULE8) (RULE7)
    else $error("full flag did not release two cycles after read");

  property p_ft_release;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (fallthrough_timing_q && rd_evt[0] && full_now[0])
      |=> queue_full_n_o[0] ##1 queue_full_n_o[0] ##1 !queue_full_n_o[0];
  endproperty
  a_ft_release: assert property (p_ft_release) // see (RULE9)
    else $error("input ready did not drop two cycles after read");

  property p_comp;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && comp_on) |=> selected_queue_full_n_o == queue_full_n_o[$past(sel_q)];
  endproperty
  a_comp: assert property (p_comp) // see (RULE10) (RULE11)
    else $error("composite flag not tracking selected queue");

  property p_ae_sync;
    @(posedge clk_i) disable iff (rst_i)
      (pfm_q && $stable(ofs_q)) |-> almost_empty_n_o[0] == !ae_cond(rcnt_q[0], e0, fallthrough_timing_q);
  endproperty
  a_ae_sync: assert property (p_ae_sync) // see (RULE12)
    else $error("almost empty does not match threshold");

  property p_af_sync;
    @(posedge clk_i) disable iff (rst_i)
      (pfm_q && $stable(ofs_q)) |-> almost_full_n_o[0] == !af_cond(wcnt_q[0], f0, fallthrough_timing_q);
  endproperty
  a_af_sync: assert property (p_af_sync) // see (RULE16)
    else $error("almost full does not match threshold");

  property p_ae_async;
    @(posedge clk_i) disable iff (rst_i)
      (!pfm_q && !rd_evt[0] && !wr_evt[0]) |=> $stable(almost_empty_n_o[0]);
  endproperty
  a_ae_async: assert property (p_ae_async) // see (RULE15) (RULE19)
    else $error("async almost empty moved without an event");

  property p_af_async;
    @(posedge clk_i) disable iff (rst_i)
      (!pfm_q && ce_i && wr_evt[0] && !rd_evt[0] && af_cond(tcnt_d[0], f0, fallthrough_timing_q))
      |=> !almost_full_n_o[0];
  endproperty
  a_af_async: assert property (p_af_async) // see (RULE18)
    else $error("async almost full not set by write");

  c_fill: cover property (@(posedge clk_i) disable iff (rst_i) full_now[0] && buf_vld);
  c_bcast: cover property (@(posedge clk_i) disable iff (rst_i) bcast && take);
  c_release: cover property (@(posedge clk_i) disable iff (rst_i) rd_evt[0] && full_now[0]);
  c_stall: cover property (@(posedge clk_i) disable iff (rst_i) !wr_ready_o);

endmodule

/* File: mqf_params.svh */
// Constants for the multi-queue status flag logic: offsets, field positions, resets, counts.
// Assumes inclusion by the package and by each design file that needs a figure.
`ifndef MQF_PARAMS_SVH
`define MQF_PARAMS_SVH

// Queue organisation
`define MQF_NUM_Q 4
`define MQF_QDEPTH 5'h10
`define MQF_CNT_W 5
`define MQF_DATA_W 40
`define MQF_SEL_W 2

// Input buffer in front of the queues
`define MQF_BUF_DEPTH 4

// Offset shift chain: four empty offsets then four full offsets, each MQF_CNT_W bits
`define MQF_OFS_CHAIN_W 40
`define MQF_EMPTY_OFS_POS 0
`define MQF_FULL_OFS_POS 20

// Offset reset values
`define MQF_EMPTY_OFS_RST 5'h02
`define MQF_FULL_OFS_RST 5'h02

// Write-view and read-view crossing latency in clock cycles
`define MQF_CROSS_CYCLES 2

`endif

/* File: mqf_pkg.sv */
// Types shared by the multi-queue status flag logic.
// Assumes mqf_params.svh is on the include path.
`include "mqf_params.svh"

package mqf_pkg;

  // Write port organisation
  typedef enum logic [1:0] {
    MODE_MUX = 2'b00,
    MODE_DEMUX = 2'b01,
    MODE_BCAST = 2'b10,
    MODE_RSVD = 2'b11
  } port_mode_e;

  typedef logic [`MQF_CNT_W-1:0] count_t;
  typedef logic [`MQF_SEL_W-1:0] qsel_t;

endpackage

/* File: mqf_buffer.sv */
// Small valid/ready FIFO holding write requests ahead of the queue flag logic.
// Assumes one clock, synchronous active-high reset, and a clock enable that freezes it.
`timescale 1ns/1ps

module mqf_buffer #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [CW-1:0] cnt_q, cnt_d;
  logic rdy_q;
  wire push = in_valid_i & rdy_q;
  wire pop = out_valid_o & out_ready_i;

  // Handshake and occupancy
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];
  assign in_ready_o = rdy_q;
  assign cnt_d = cnt_q + CW'(push) - CW'(pop);

  // Pointer wrap at the buffer depth
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // Pointers, count and registered ready
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end else if (ce_i) begin
      if (push) wp_q <= bump(wp_q);
      if (pop) rp_q <= bump(rp_q);
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != CW'(DEPTH));
    end
  end

  // Storage
  always_ff @(posedge clk_i) begin
    if (ce_i && push) mem_q[wp_q] <= in_data_i;
  end

endmodule

/* File: queue_consumer_model.sv */
// Consumer-side model: counts words stored per queue and issues queue reads on request.
// Assumes the flag logic's clock and its synchronous active-high reset.
`timescale 1ns/1ps

module queue_consumer_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] store_en_i,
  input wire logic [3:0] read_req_i,
  input wire logic slow_i,
  output logic [3:0] rd_en_o,
  output logic [3:0][7:0] stored_o
);
  logic [3:0] pend_q;
  logic [1:0] wait_q;

  // Count every stored word per queue
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (rst_i) stored_o[i] <= 8'h00;
      else if (store_en_i[i]) stored_o[i] <= stored_o[i] + 8'h01;
    end
  end

  // A read goes out on the next cycle, or after three idle cycles when slow; one cycle each
  always_ff @(posedge clk_i) begin
    rd_en_o <= 4'h0;
    if (rst_i) begin
      pend_q <= 4'h0;
      wait_q <= 2'h0;
    end else if (read_req_i != 4'h0) begin
      pend_q <= read_req_i;
      wait_q <= slow_i ? 2'h3 : 2'h0;
    end else if (pend_q != 4'h0 && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (pend_q != 4'h0) begin
      rd_en_o <= pend_q;
      pend_q <= 4'h0;
    end
  end
endmodule

/* File: tb.sv */
// Self-checking bench for the multi-queue status flag logic.
// Assumes mqf_pkg and the consumer model are compiled first.
`timescale 1ns/1ps
`include "mqf_params.svh"

module tb;
  import mqf_pkg::*;
  localparam int D = `MQF_QDEPTH;
  localparam int LIMIT = 20000;
  logic clk_i, rst_i, ce_i, fsel, flag_timing_select, sclk, sen_n, wr_valid_i, slow, wr_ready_o;
  logic [1:0] port_mode_i, wr_sel_i;
  logic [39:0] wr_data_i, store_data_o;
  logic [3:0] read_req, rd_en, store_en_o, queue_full_n_o, almost_empty_n_o, almost_full_n_o;
  logic selected_queue_full_n_o, fallthrough_timing_o;
  logic [3:0][7:0] stored;
  int seed, fail_count, checked, cycles, sent_wp, sent_rp;
  logic [39:0] sent[16];
  int cnt[4], n[4], m[4];

  multi_queue_status_flag_logic dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .fallthrough_select_serial_in_i(fsel), .flag_timing_select_i(flag_timing_select),
    .port_mode_i(port_mode_i), .serial_clk_i(sclk), .serial_load_enable_n_i(sen_n),
    .wr_valid_i(wr_valid_i), .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i),
    .wr_ready_o(wr_ready_o), .rd_en_i(rd_en), .store_en_o(store_en_o),
    .store_data_o(store_data_o), .queue_full_n_o(queue_full_n_o),
    .selected_queue_full_n_o(selected_queue_full_n_o), .almost_empty_n_o(almost_empty_n_o),
    .almost_full_n_o(almost_full_n_o), .fallthrough_timing_o(fallthrough_timing_o));

  queue_consumer_model consumer (.clk_i(clk_i), .rst_i(rst_i), .store_en_i(store_en_o),
    .read_req_i(read_req), .slow_i(slow), .rd_en_o(rd_en), .stored_o(stored));

  // Each stored word must be the oldest word handed in, byte by byte
  always @(negedge clk_i) begin
    if (!rst_i && store_en_o != 4'h0) begin
      for (int b = 0; b < 5; b++) begin
        chk(store_data_o[8*b +: 8], sent[sent_rp % 16][8*b +: 8]);
      end
      sent_rp++;
    end
  end

  // Clock at 25 MHz
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected {full or input-ready, almost-empty, almost-full} for a count
  function automatic logic [2:0] exp_fl(input int c, input int n, input int m, input bit ft);
    exp_fl[2] = ft ? (c >= D + 1) : (c < D);
    exp_fl[1] = ft ? (c > n - 1) : (c > n);
    exp_fl[0] = ft ? (c + m < D + 1) : (c + m < D);
  endfunction

  // Present one write and hold it until taken, giving up after lim cycles
  task automatic wr(input logic [1:0] s, input int lim, output bit ok);
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    @(posedge clk_i);
    wr_valid_i <= 1'b1;
    wr_sel_i <= s;
    wr_data_i <= r[39:0];
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge clk_i);
      ok = (wr_ready_o === 1'b1);
      @(posedge clk_i);
    end
    wr_valid_i <= 1'b0;
    if (ok) begin
      sent[sent_wp % 16] = r[39:0];
      sent_wp++;
    end
  endtask

  // Ask the consumer for reads; returns just after the read edge
  task automatic rd(input logic [3:0] mask, input bit s);
    @(posedge clk_i);
    read_req <= mask;
    slow <= s;
    @(posedge clk_i);
    read_req <= 4'h0;
    for (int i = 0; i < 8 && rd_en !== mask; i++) @(negedge clk_i);
    @(posedge clk_i);
  endtask

  // Shift the offset chain in, first bit first, one bit per serial clock rise
  task automatic load_ofs(input logic [39:0] v);
    for (int i = 39; i >= 0; i--) begin
      @(posedge clk_i);
      fsel <= v[i];
      sclk <= 1'b0;
      sen_n <= 1'b0;
      @(posedge clk_i);
      sclk <= 1'b1;
    end
    @(posedge clk_i);
    sclk <= 1'b0;
    sen_n <= 1'b1;
  endtask

  task automatic check_all(input bit ft);
    logic [2:0] e;
    repeat (8) @(negedge clk_i);
    for (int i = 0; i < 4; i++) begin
      e = exp_fl(cnt[i], n[i], m[i], ft);
      chk({5'h00, queue_full_n_o[i], almost_empty_n_o[i], almost_full_n_o[i]}, {5'h00, e});
    end
    e = exp_fl(cnt[wr_sel_i], n[wr_sel_i], m[wr_sel_i], ft);
    chk({7'h00, selected_queue_full_n_o}, {7'h00, e[2]});
  endtask

  task automatic run_pass(input bit ft);
    logic [39:0] chain;
    logic [2:0] e;
    bit ok;
    int cap, taken, q;
    cap = ft ? D + 1 : D;
    @(posedge clk_i);
    rst_i <= 1'b1;
    fsel <= ft;
    flag_timing_select <= !ft;
    port_mode_i <= ft ? MODE_BCAST : MODE_DEMUX;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    sent_rp = sent_wp;
    @(negedge clk_i);
    chk({7'h00, fallthrough_timing_o}, {7'h00, ft});
    chk({4'h0, queue_full_n_o}, {4'h0, {4{!ft}}});
    for (int i = 0; i < 4; i++) begin
      cnt[i] = 0;
      n[i] = ft ? ({$random(seed)} % 6) + 1 : 2;
      m[i] = ft ? ({$random(seed)} % 6) + 1 : 2;
      chain[5*i +: 5] = n[i][4:0];
      chain[20 + 5*i +: 5] = m[i][4:0];
    end
    if (ft) load_ofs(chain);
    // Fill to capacity, flags checked after every word
    for (int k = 1; k <= cap; k++) begin
      wr(ft ? 2'($random(seed)) : 2'h0, 4, ok);
      for (int i = 0; i < 4; i++) if (ft || i == 0) cnt[i] = k;
      check_all(ft);
    end
    for (int i = 0; i < 4; i++) chk(stored[i], 8'(cnt[i]));
    // Composite follows the selection
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      wr_sel_i <= 2'(s);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      e = exp_fl(cnt[s], n[s], m[s], ft);
      chk({7'h00, selected_queue_full_n_o}, {7'h00, e[2]});
    end
    // One read from a full queue frees space two cycles later
    q = ft ? 2 : 0;
    rd(4'(1 << q), ft);
    @(negedge clk_i);
    chk({7'h00, queue_full_n_o[q]}, {7'h00, ft});
    @(negedge clk_i);
    chk({7'h00, queue_full_n_o[q]}, {7'h00, ft});
    @(negedge clk_i);
    chk({7'h00, queue_full_n_o[q]}, {7'h00, !ft});
    cnt[q] = cnt[q] - 1;
    if (!ft) begin
      wr(2'h0, 4, ok);
      cnt[0] = cap;
      wr(2'h1, 4, ok);
      cnt[1] = 1;
      check_all(ft);
      chk(stored[1], 8'h01);
      wr(2'h0, 4, ok);
      check_all(ft);
      chk(stored[0], 8'(cap + 1));
      // A read while the clock enable is low must change nothing
      @(posedge clk_i);
      ce_i <= 1'b0;
      rd(4'h1, 1'b0);
      repeat (4) @(negedge clk_i);
      chk({7'h00, queue_full_n_o[0]}, 8'h00);
      chk(stored[0], 8'(cap + 1));
      @(posedge clk_i);
      ce_i <= 1'b1;
      @(posedge clk_i);
      port_mode_i <= MODE_MUX;
      repeat (3) @(negedge clk_i);
      chk({7'h00, selected_queue_full_n_o}, 8'h01);
    end else begin
      wr(2'($random(seed)), 4, ok);
      check_all(ft);
      for (int i = 0; i < 4; i++) chk(stored[i], 8'(cap));
      taken = 0;
      while (ok && taken < 8) begin
        wr(2'h0, 3, ok);
        if (ok) taken++;
      end
      @(negedge clk_i);
      chk({7'h00, wr_ready_o}, 8'h00);
      repeat (6) rd(4'hf, 1'b1);
      repeat (10) @(negedge clk_i);
      chk({7'h00, wr_ready_o}, 8'h01);
      for (int i = 0; i < 4; i++) chk(stored[i], 8'(cap + 1 + taken));
    end
  endtask

  initial begin
    seed = 32'h29b0f97e;
    rst_i = 1'b1;
    ce_i = 1'b1;
    fsel = 1'b0;
    flag_timing_select = 1'b1;
    sclk = 1'b0;
    sen_n = 1'b1;
    port_mode_i = MODE_DEMUX;
    wr_valid_i = 1'b0;
    wr_sel_i = 2'h0;
    wr_data_i = 40'h0;
    read_req = 4'h0;
    slow = 1'b0;
    run_pass(1'b0);
    $display("test standard timing with demux done");
    run_pass(1'b1);
    $display("test input-ready timing with broadcast done");
    print_verdict();
  end
endmodule
